//--- design/csf_pkg.sv
// constants and types of the cpu status flags and register bank block
// assumes a single 200 MHz clock domain shared with the execution unit
package csf_pkg;

  // program status word layout: bank pointer high byte, condition codes low byte
  localparam int unsigned PSW_W       = 16;
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned BP_LSB      = 8;
  localparam int unsigned FLAG_HALF   = 7;
  localparam int unsigned FLAG_IE     = 6;
  localparam int unsigned LEVEL_LSB   = 4;
  localparam int unsigned FLAG_NEG    = 3;
  localparam int unsigned FLAG_ZERO   = 2;
  localparam int unsigned FLAG_OVF    = 1;
  localparam int unsigned FLAG_CARRY  = 0;

  // interrupt level field reset value: lowest level, level 1 and 2 requests outrank it
  localparam logic [1:0]  LEVEL_RESET = 2'h3;
  localparam logic [15:0] PSW_RESET   = 16'h0030;

  // bank pointer to memory address conversion
  localparam int unsigned BANK_IDX_LSB = 3;
  localparam int unsigned BANK_IDX_W   = 4;
  localparam int unsigned REG_SEL_W    = 3;
  localparam logic [15:0] BANK_BASE    = 16'h0100;

  // memory layout
  localparam logic [15:0] IO_TOP       = 16'h007f;
  localparam logic [15:0] VECTOR_BASE  = 16'hffc0;

  // software register port indices
  localparam int unsigned ADDR_W   = 4;
  localparam logic [3:0]  IDX_PSW  = 4'h0;
  localparam logic [3:0]  IDX_ACC  = 4'h1;
  localparam logic [3:0]  IDX_TMP  = 4'h2;
  localparam logic [3:0]  IDX_IP   = 4'h3;
  localparam logic [3:0]  IDX_IXP  = 4'h4;
  localparam logic [3:0]  IDX_EXP  = 4'h5;
  localparam logic [3:0]  IDX_STP  = 4'h6;

  typedef enum logic [3:0] {
    CSF_OP_NOP  = 4'h0,
    CSF_OP_ADD  = 4'h1,
    CSF_OP_ADDC = 4'h2,
    CSF_OP_SUB  = 4'h3,
    CSF_OP_SUBC = 4'h4,
    CSF_OP_AND  = 4'h5,
    CSF_OP_OR   = 4'h6,
    CSF_OP_XOR  = 4'h7,
    CSF_OP_ROLC = 4'h8,
    CSF_OP_RORC = 4'h9
  } csf_op_t;

  typedef enum logic [1:0] {
    CSF_REG_IO     = 2'h0,
    CSF_REG_DATA   = 2'h1,
    CSF_REG_PROG   = 2'h2,
    CSF_REG_VECTOR = 2'h3
  } csf_region_t;

endpackage

//--- design/csf_core.sv
// cpu status flags, dedicated pointer registers and register bank addressing
// assumes the execution unit and software port run on I_CLK and issue one-cycle strobes
//
// Behaviour
// - half-carry flag follows carry or borrow between bit 3 and bit 4.
// - interrupt-enable flag at 1 permits interrupt acceptance, at 0 blocks all.
// - reset clears the interrupt-enable flag.
// - level codes 00/01 level 1, 10 level 2, 11 none; higher request only.
// - negative flag copies the result's most significant bit.
// - zero flag set when the result is zero, cleared otherwise.
// - overflow flag set on two's complement overflow, cleared otherwise.
// - carry flag set on carry or borrow out of bit 7, or out of bit 15 on 16-bit ops.
// - shifts load the carry flag with the bit shifted out.
// - status word: bank pointer high byte, condition code byte low byte.
// - eight 8-bit registers per bank, sixteen banks, bank chosen by pointer.
// - 16-bit accumulator; 8-bit instructions use only its lower byte.
// - 16-bit temporary accumulator is second operand, lower byte for 8-bit.
// - instruction, index, extra and stack pointers are each 16 bits.
// - memory map: I/O lowest, data above, program and vectors at top.
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module csf_core
  import csf_pkg::*;
#(
  parameter logic [15:0] RESET_IP  = 16'h0000,
  parameter logic [15:0] PROG_BASE = 16'hc000
) (
  // clock and reset
  input  wire logic                      I_CLK,
  input  wire logic                      I_NRST,
  // software register port
  input  wire logic [csf_pkg::ADDR_W-1:0] I_ADDR,
  input  wire logic [15:0]               I_WDATA,
  input  wire logic                      I_WR,
  input  wire logic                      I_RD,
  output logic      [15:0]               O_RDATA,
  // execution unit
  input  wire logic                      I_EXEC,
  input  wire csf_pkg::csf_op_t          I_OP,
  input  wire logic                      I_WIDE,
  input  wire logic                      I_IP_STEP,
  // interrupt request check
  input  wire logic                      I_IRQ_REQ,
  input  wire logic [1:0]                I_IRQ_LEVEL,
  output logic                           O_IRQ_ACCEPT,
  // banked register and memory layout lookup
  input  wire logic [csf_pkg::REG_SEL_W-1:0] I_REG_SEL,
  output logic      [15:0]               O_REG_ADDR,
  input  wire logic [15:0]               I_MEM_ADDR,
  output csf_pkg::csf_region_t           O_REGION,
  // state views
  output logic      [15:0]               O_PSW,
  output logic      [15:0]               O_ACC,
  output logic      [15:0]               O_IP
);

  import csf_pkg::*;

  typedef struct packed {
    logic [15:0] psw;
    logic [15:0] acc;
    logic [15:0] tmp;
    logic [15:0] ip;
    logic [15:0] ixp;
    logic [15:0] exp;
    logic [15:0] stp;
    logic [15:0] rdata;
    logic        irq_accept;
    logic [15:0] reg_addr;
    csf_region_t region;
  } csf_state_t;

  typedef struct packed {
    logic [15:0] res;
    logic        carry;
    logic        half;
    logic        ovf;
  } csf_sum_t;

  csf_state_t st;
  csf_state_t next_st;

  // codes 00 and 01 both mean level 1, the highest
  function automatic logic [1:0] level_of(input logic [1:0] code);
    level_of = (code == 2'h0) ? 2'h1 : code;
  endfunction

  // add or subtract on 8 or 16 bits; subtraction adds the complement,
  // so carry out inverted gives the borrow
  function automatic csf_sum_t add_sub(input logic [15:0] a,
                                       input logic [15:0] b,
                                       input logic        cin,
                                       input logic        sub,
                                       input logic        wide);
    csf_sum_t    r;
    logic [15:0] bx;
    logic        cx;
    logic [16:0] s16;
    logic [8:0]  s8;
    logic [4:0]  s4;
    logic        msb_a;
    logic        msb_b;
    logic        msb_r;
    bx  = sub ? ~b : b;
    cx  = sub ? ~cin : cin;
    s16 = {1'b0, a} + {1'b0, bx} + {16'h0000, cx};
    s8  = {1'b0, a[7:0]} + {1'b0, bx[7:0]} + {8'h00, cx};
    s4  = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cx};
    r.res   = wide ? s16[15:0] : {a[15:8], s8[7:0]};
    r.carry = (wide ? s16[16] : s8[8]) ^ sub;
    r.half  = s4[4] ^ sub;
    msb_a   = wide ? a[15] : a[7];
    msb_b   = wide ? bx[15] : bx[7];
    msb_r   = wide ? s16[15] : s8[7];
    r.ovf   = (msb_a == msb_b) && (msb_r != msb_a);
    add_sub = r;
  endfunction

  function automatic csf_region_t region_of(input logic [15:0] addr);
    csf_region_t r;
    if (addr <= IO_TOP) begin
      r = CSF_REG_IO;
    end else if (addr >= VECTOR_BASE) begin
      r = CSF_REG_VECTOR;
    end else if (addr >= PROG_BASE) begin
      r = CSF_REG_PROG;
    end else begin
      r = CSF_REG_DATA;
    end
    region_of = r;
  endfunction

  csf_sum_t    sum;
  logic [15:0] res;
  logic [15:0] lres;
  logic        shift_out;
  logic        msb;
  logic        is_zero;
  logic        arith;
  logic        logic_op;
  logic        shift_op;
  logic [7:0]  bank_ptr;
  logic [BANK_IDX_W-1:0] bank_idx;

  always_comb begin
    next_st   = st;
    sum       = add_sub(st.acc, st.tmp, st.psw[FLAG_CARRY],
                        (I_OP == CSF_OP_SUB) || (I_OP == CSF_OP_SUBC),
                        I_WIDE);
    res       = st.acc;
    lres      = st.acc;
    shift_out = st.psw[FLAG_CARRY];
    arith     = 1'b0;
    logic_op  = 1'b0;
    shift_op  = 1'b0;

    // plain adds and subtracts ignore the incoming carry
    if ((I_OP == CSF_OP_ADD) || (I_OP == CSF_OP_SUB)) begin
      sum = add_sub(st.acc, st.tmp, 1'b0, I_OP == CSF_OP_SUB, I_WIDE);
    end

    case (I_OP)
      CSF_OP_ADD, CSF_OP_ADDC, CSF_OP_SUB, CSF_OP_SUBC: begin
        arith = 1'b1;
        res   = sum.res;
      end
      CSF_OP_AND: begin
        logic_op = 1'b1;
        lres     = st.acc & st.tmp;
      end
      CSF_OP_OR: begin
        logic_op = 1'b1;
        lres     = st.acc | st.tmp;
      end
      CSF_OP_XOR: begin
        logic_op = 1'b1;
        lres     = st.acc ^ st.tmp;
      end
      CSF_OP_ROLC: begin
        shift_op  = 1'b1;
        shift_out = I_WIDE ? st.acc[15] : st.acc[7];
        lres      = I_WIDE ? {st.acc[14:0], st.psw[FLAG_CARRY]}
                           : {st.acc[15:8], st.acc[6:0], st.psw[FLAG_CARRY]};
      end
      CSF_OP_RORC: begin
        shift_op  = 1'b1;
        shift_out = st.acc[0];
        lres      = I_WIDE ? {st.psw[FLAG_CARRY], st.acc[15:1]}
                           : {st.acc[15:8], st.psw[FLAG_CARRY], st.acc[7:1]};
      end
      default: begin
        arith = 1'b0;
      end
    endcase

    // byte-wide logic ops leave the accumulator's upper byte alone
    if (logic_op && !I_WIDE) begin
      lres = {st.acc[15:8], lres[7:0]};
    end
    if (!arith) begin
      res = lres;
    end
    msb     = I_WIDE ? res[15] : res[7];
    is_zero = I_WIDE ? (res == 16'h0000) : (res[7:0] == 8'h00);

    // software writes land first so that a flag update by an instruction in the
    // same cycle wins over a software clear
    if (I_WR) begin
      if (I_ADDR == IDX_PSW) begin
        next_st.psw = I_WDATA;
      end else if (I_ADDR == IDX_ACC) begin
        next_st.acc = I_WDATA;
      end else if (I_ADDR == IDX_TMP) begin
        next_st.tmp = I_WDATA;
      end else if (I_ADDR == IDX_IP) begin
        next_st.ip = I_WDATA;
      end else if (I_ADDR == IDX_IXP) begin
        next_st.ixp = I_WDATA;
      end else if (I_ADDR == IDX_EXP) begin
        next_st.exp = I_WDATA;
      end else if (I_ADDR == IDX_STP) begin
        next_st.stp = I_WDATA;
      end
    end

    if (I_IP_STEP) begin
      next_st.ip = st.ip + 16'h0001;
    end

    if (I_EXEC && (arith || logic_op || shift_op)) begin
      next_st.acc             = res;
      next_st.psw[FLAG_NEG]   = msb;
      next_st.psw[FLAG_ZERO]  = is_zero;
      next_st.psw[FLAG_OVF]   = arith ? sum.ovf : 1'b0;
      if (arith) begin
        next_st.psw[FLAG_HALF]  = sum.half;
        next_st.psw[FLAG_CARRY] = sum.carry;
      end else if (shift_op) begin
        next_st.psw[FLAG_CARRY] = shift_out;
      end
    end

    // read data stand only in the cycle after the strobe
    next_st.rdata = 16'h0000;
    if (I_RD) begin
      if (I_ADDR == IDX_PSW) begin
        next_st.rdata = st.psw;
      end else if (I_ADDR == IDX_ACC) begin
        next_st.rdata = st.acc;
      end else if (I_ADDR == IDX_TMP) begin
        next_st.rdata = st.tmp;
      end else if (I_ADDR == IDX_IP) begin
        next_st.rdata = st.ip;
      end else if (I_ADDR == IDX_IXP) begin
        next_st.rdata = st.ixp;
      end else if (I_ADDR == IDX_EXP) begin
        next_st.rdata = st.exp;
      end else if (I_ADDR == IDX_STP) begin
        next_st.rdata = st.stp;
      end
    end

    // smaller level number is the higher priority
    next_st.irq_accept = I_IRQ_REQ && st.psw[FLAG_IE] &&
                         (level_of(I_IRQ_LEVEL) <
                          level_of(st.psw[LEVEL_LSB +: 2]));

    bank_ptr = st.psw[BP_LSB +: BYTE_W];
    bank_idx = bank_ptr[BANK_IDX_LSB +: BANK_IDX_W];
    next_st.reg_addr = BANK_BASE + {9'h000, bank_idx, I_REG_SEL};

    next_st.region = region_of(I_MEM_ADDR);
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      st            <= '0;
      st.psw        <= PSW_RESET;
      st.ip         <= RESET_IP;
      st.reg_addr   <= BANK_BASE;
      st.region     <= CSF_REG_IO;
    end else begin
      st <= next_st;
    end
  end

  assign O_RDATA      = st.rdata;
  assign O_IRQ_ACCEPT = st.irq_accept;
  assign O_REG_ADDR   = st.reg_addr;
  assign O_REGION     = st.region;
  assign O_PSW        = st.psw;
  assign O_ACC        = st.acc;
  assign O_IP         = st.ip;

endmodule

`default_nettype wire

//--- verif/csf_core_monitor.sv
// concurrent checks on the status flag block, watching its top ports only
// assumes one clock domain with strobes driven just after the rising edge
`timescale 1ns/100ps
`default_nettype none
module csf_core_monitor
  import csf_pkg::*;
(
  // clock and reset
  input wire logic                 I_CLK,
  input wire logic                 I_NRST,
  // execution side
  input wire logic                 I_WR,
  input wire logic                 I_EXEC,
  input wire csf_pkg::csf_op_t     I_OP,
  input wire logic                 I_WIDE,
  input wire logic                 I_IP_STEP,
  input wire logic [15:0]          O_PSW,
  input wire logic [15:0]          O_ACC,
  input wire logic [15:0]          O_IP,
  // interrupt check and lookups
  input wire logic                 I_IRQ_REQ,
  input wire logic [1:0]           I_IRQ_LEVEL,
  input wire logic [2:0]           I_REG_SEL,
  input wire logic [15:0]          I_MEM_ADDR,
  input wire logic                 O_IRQ_ACCEPT,
  input wire logic [15:0]          O_REG_ADDR,
  input wire csf_pkg::csf_region_t O_REGION
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  // codes 00 and 01 both stand for the top level
  function automatic logic [1:0] lvl_num(input logic [1:0] c);
    return (c == 2'h0) ? 2'h1 : c;
  endfunction
  wire take_irq = I_IRQ_REQ & O_PSW[FLAG_IE] & (lvl_num(I_IRQ_LEVEL) < lvl_num(O_PSW[5:4]));
  wire run8 = I_EXEC & ~I_WIDE;
  wire [15:0] bank_addr = BANK_BASE + {9'h0, O_PSW[14:11], I_REG_SEL};

  irq_match_a: assert property (1'b1 |=> O_IRQ_ACCEPT == $past(take_irq))
    else $error("interrupt accept disagrees with enable and level");
  reset_ie_a: assert property ($rose(I_NRST) |-> !O_PSW[FLAG_IE] && O_PSW[5:4] == 2'h3)
    else $error("interrupts not blocked after reset");
  bank_addr_a: assert property (1'b1 |=> O_REG_ADDR == $past(bank_addr))
    else $error("banked register address wrong");
  flag_nz_a: assert property (run8 && I_OP != CSF_OP_NOP |=>
    O_PSW[FLAG_NEG] == O_ACC[7] && O_PSW[FLAG_ZERO] == (O_ACC[7:0] == 8'h0))
    else $error("negative or zero flag wrong");
  logic_flags_a: assert property (I_EXEC && I_OP inside {CSF_OP_AND, CSF_OP_OR, CSF_OP_XOR}
    |=> !O_PSW[FLAG_OVF] && $stable(O_PSW[FLAG_CARRY]))
    else $error("logic op touched overflow or carry");
  shift_carry_a: assert property (run8 && I_OP == CSF_OP_RORC |=> O_PSW[FLAG_CARRY] == $past(O_ACC[0]))
    else $error("shift did not load carry with bit out");
  ip_step_a: assert property (I_IP_STEP && !I_WR |=> O_IP == $past(O_IP) + 16'h1)
    else $error("instruction pointer did not step");
  region_io_a: assert property (I_MEM_ADDR <= IO_TOP |=> O_REGION == CSF_REG_IO)
    else $error("low address not classed as io");

  cover property (O_IRQ_ACCEPT);
  cover property (run8 && I_OP == CSF_OP_SUBC);
  cover property (I_IP_STEP [*3]);
  cover property (I_EXEC && I_WIDE && I_OP == CSF_OP_SUBC);
endmodule

bind csf_core csf_core_monitor u_mon (
  .I_CLK(I_CLK), .I_NRST(I_NRST), .I_WR(I_WR), .I_EXEC(I_EXEC), .I_OP(I_OP),
  .I_WIDE(I_WIDE), .I_IP_STEP(I_IP_STEP), .O_PSW(O_PSW), .O_ACC(O_ACC), .O_IP(O_IP),
  .I_IRQ_REQ(I_IRQ_REQ), .I_IRQ_LEVEL(I_IRQ_LEVEL), .I_REG_SEL(I_REG_SEL),
  .I_MEM_ADDR(I_MEM_ADDR), .O_IRQ_ACCEPT(O_IRQ_ACCEPT), .O_REG_ADDR(O_REG_ADDR),
  .O_REGION(O_REGION)
);
`default_nettype wire

//--- verif/csf_exec_model.sv
// execution unit stand-in driving instruction and pointer step inputs
// assumes the bench calls its tasks from one process at a time
`timescale 1ns/100ps
`default_nettype none
module csf_exec_model
  import csf_pkg::*;
(
  input  wire logic           clk,
  output var csf_pkg::csf_op_t op,
  output var logic            exec,
  output var logic            wide,
  output var logic            step
);
  initial begin
    exec = 1'b0;
    wide = 1'b0;
    step = 1'b0;
    op   = CSF_OP_NOP;
  end
  // width follows the caller so that both byte and word paths are exercised
  task automatic issue(input csf_op_t o, input logic w);
    @(posedge clk);
    exec <= 1'b1;
    op   <= o;
    wide <= w;
    @(posedge clk);
    exec <= 1'b0;
    op   <= CSF_OP_NOP;
    wide <= 1'b0;
  endtask
  task automatic steps(input int n);
    @(posedge clk);
    step <= 1'b1;
    repeat (n) @(posedge clk);
    step <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- verif/tb_cpu_status_flags_and_register_banks.sv
// self-checking bench for the status flag and register bank block
// assumes csf_core, its bound checker and the execution stand-in are compiled
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_status_flags_and_register_banks;
  import csf_pkg::*;
  logic I_CLK = 1'b0, I_NRST = 1'b0, I_WR = 1'b0, I_RD = 1'b0, I_IRQ_REQ = 1'b0;
  logic [3:0] I_ADDR = 4'h0;
  logic [15:0] I_WDATA = 16'h0, I_MEM_ADDR = 16'h0;
  logic [1:0] I_IRQ_LEVEL = 2'h0;
  logic [2:0] I_REG_SEL = 3'h0;
  logic [15:0] O_RDATA, O_REG_ADDR, O_PSW, O_ACC, O_IP, acc, tmp, psw, r;
  logic O_IRQ_ACCEPT, I_EXEC, I_WIDE, I_IP_STEP, e, w;
  csf_op_t I_OP, op;
  csf_region_t O_REGION;
  int bad_count = 0, comparisons = 0;
  logic [31:0] seed = 32'h6369;
  logic [7:0] cb [4] = '{8'h7f, 8'hff, 8'h00, 8'h80};
  logic [15:0] ca [6] = '{16'h007f, 16'h0080, 16'hbfff, 16'hc000, 16'hffbf, 16'hffc0};
  always #2.5 I_CLK = ~I_CLK;
  csf_core dut (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_EXEC(I_EXEC), .I_OP(I_OP),
    .I_WIDE(I_WIDE), .I_IP_STEP(I_IP_STEP), .I_IRQ_REQ(I_IRQ_REQ), .I_IRQ_LEVEL(I_IRQ_LEVEL),
    .O_IRQ_ACCEPT(O_IRQ_ACCEPT), .I_REG_SEL(I_REG_SEL), .O_REG_ADDR(O_REG_ADDR),
    .I_MEM_ADDR(I_MEM_ADDR), .O_REGION(O_REGION), .O_PSW(O_PSW), .O_ACC(O_ACC), .O_IP(O_IP));
  csf_exec_model px (.clk(I_CLK), .op(I_OP), .exec(I_EXEC), .wide(I_WIDE), .step(I_IP_STEP));
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  function automatic logic [1:0] lv(input logic [1:0] c);
    return (c == 2'h0) ? 2'h1 : c;
  endfunction
  // returns the expected accumulator and status word after a byte or word op
  function automatic logic [31:0] alu(input csf_op_t o, input logic w,
                                      input logic [15:0] a, t, p);
    logic [16:0] s;
    logic [15:0] x, y, q;
    logic [4:0] n;
    logic ci, ar, sb, lg, v, m, z, c, xm, ym;
    ar = o inside {CSF_OP_ADD, CSF_OP_ADDC, CSF_OP_SUB, CSF_OP_SUBC};
    sb = o inside {CSF_OP_SUB, CSF_OP_SUBC};
    lg = o inside {CSF_OP_AND, CSF_OP_OR, CSF_OP_XOR};
    ci = (o == CSF_OP_ADDC || o == CSF_OP_SUBC) & p[0];
    x = w ? a : {8'h00, a[7:0]};
    y = w ? t : {8'h00, t[7:0]};
    s = {1'b0, x};
    n = 5'h0;
    case (o)
      CSF_OP_ADD, CSF_OP_ADDC: begin
        s = x + y + ci;
        n = a[3:0] + t[3:0] + ci;
      end
      CSF_OP_SUB, CSF_OP_SUBC: begin
        s = x - y - ci;
        n = a[3:0] - t[3:0] - ci;
      end
      CSF_OP_AND: s = {1'b0, x & y};
      CSF_OP_OR: s = {1'b0, x | y};
      CSF_OP_XOR: s = {1'b0, x ^ y};
      CSF_OP_ROLC: s = w ? {a, p[0]} : {8'h00, a[7:0], p[0]};
      CSF_OP_RORC: s = w ? {a[0], p[0], a[15:1]} : {8'h00, a[0], p[0], a[7:1]};
      default: ;
    endcase
    xm = w ? a[15] : a[7];
    ym = w ? t[15] : t[7];
    m = w ? s[15] : s[7];
    z = w ? (s[15:0] == 16'h0) : (s[7:0] == 8'h0);
    c = w ? s[16] : s[8];
    v = ar & ((xm ~^ ym) ^ sb) & (m ^ xm);
    q = w ? s[15:0] : {a[15:8], s[7:0]};
    return {q, p[15:8], ar ? n[4] : p[7], p[6:4], m, z, v, lg ? p[0] : c};
  endfunction
  task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
    comparisons++;
    if (g !== x) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge I_CLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_CLK);
    I_WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge I_CLK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    #1 d = O_RDATA;
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge I_CLK);
    I_NRST <= 1'b1;
    #1 chk("psw reset", PSW_RESET, O_PSW);
    for (int i = 0; i < 180; i++) begin
      acc = rnd();
      tmp = rnd();
      psw = rnd();
      r = rnd();
      if (i < 16) begin
        acc[7:0] = cb[i % 4];
        tmp[7:0] = cb[i / 4];
      end
      wr(IDX_ACC, acc);
      wr(IDX_TMP, tmp);
      wr(IDX_PSW, psw);
      // second op follows after one idle cycle and must see the first op's result
      for (int k = 0; k < 2; k++) begin
        op = csf_op_t'(4'((i + k * 4) % 9 + 1));
        w = (i >= 16) & r[k];
        px.issue(op, w);
        {acc, psw} = alu(op, w, acc, tmp, psw);
        #1 chk("acc", acc, O_ACC);
        chk("psw", psw, O_PSW);
      end
    end
    for (int i = 0; i < 64; i++) begin
      psw = rnd();
      psw[6:4] = 3'(i);
      r = rnd();
      wr(IDX_PSW, psw);
      I_IRQ_REQ <= ~i[5];
      I_IRQ_LEVEL <= 2'(i >> 3);
      I_REG_SEL <= r[2:0];
      I_MEM_ADDR <= (i < 6) ? ca[i] : rnd();
      @(posedge I_CLK);
      e = ~i[5] & psw[6] & (lv(I_IRQ_LEVEL) < lv(psw[5:4]));
      #1 chk("accept", {15'h0, e}, {15'h0, O_IRQ_ACCEPT});
      chk("bank addr", BANK_BASE + {9'h0, psw[14:11], r[2:0]}, O_REG_ADDR);
      r = (I_MEM_ADDR <= IO_TOP) ? 16'h0 : (I_MEM_ADDR >= VECTOR_BASE) ? 16'h3 :
          (I_MEM_ADDR >= 16'hc000) ? 16'h2 : 16'h1;
      chk("region", r, {14'h0, O_REGION});
    end
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      wr(4'(k), r);
      rd(4'(k), acc);
      chk("rdata", (k < 7) ? r : 16'h0, acc);
      @(posedge I_CLK);
      #1 chk("rdata idle", 16'h0, O_RDATA);
    end
    wr(IDX_IP, 16'hfffe);
    px.steps(3);
    #1 chk("ip", 16'h0001, O_IP);
    I_NRST <= 1'b0;
    @(posedge I_CLK);
    I_NRST <= 1'b1;
    #1 chk("psw reset", PSW_RESET, O_PSW);
    chk("acc reset", 16'h0000, O_ACC);
    chk("ip reset", 16'h0000, O_IP);
    report_and_stop();
  end
endmodule
`default_nettype wire
